// File: verilog/awsc_top.v
// area wait-state control: register bank on AHB-Lite plus per-area wait selection
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "awsc_consts.vh"
module awsc_top (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [11:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   input  wire        ext_req,
   input  wire [2:0]  ext_area,
   output wire        ext_busy,
   output wire        ext_done,
   output wire [2:0]  ext_wait_count,
   output wire        ext_three_state,
   output wire [3:0]  ext_states
);
   // ==========================================
   // registers
   reg [15:0] upper_area_wait_count_r;
   reg [15:0] lower_area_wait_count_r;
   reg [7:0]  access_state_control_r;
   reg        wr_pend_r;
   reg [11:0] wr_addr_r;
   reg        rd_pend_r;
   reg [11:0] rd_addr_r;
   reg [7:0]  last_area_r;
   wire       seq_busy;
   wire       seq_done;
   wire [3:0] seq_states;
   wire       take = hsel & hready & htrans[1];
   // ==========================================
   // AHB-Lite slave: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         wr_addr_r <= 12'h000;
         rd_addr_r <= 12'h000;
      end else begin
         wr_pend_r <= take & hwrite;
         rd_pend_r <= take & ~hwrite;
         if (take) begin
            wr_addr_r <= haddr;
            rd_addr_r <= haddr;
         end
      end
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         upper_area_wait_count_r <= `AWSC_WAIT_RESET;
         lower_area_wait_count_r <= `AWSC_WAIT_RESET;
         access_state_control_r  <= `AWSC_AST_RESET;
      end else if (wr_pend_r) begin
         case (wr_addr_r)
            `AWSC_OFS_UPPER_WAIT:
               upper_area_wait_count_r <= hwdata[15:0] & `AWSC_WMASK;
            `AWSC_OFS_LOWER_WAIT:
               lower_area_wait_count_r <= hwdata[15:0] & `AWSC_WMASK;
            `AWSC_OFS_ACCESS_STATE:
               access_state_control_r  <= hwdata[15:8];
            default: ;
         endcase
      end
   end
   // forward a write just completing so back-to-back write then read sees it
   wire fw_u = wr_pend_r & (wr_addr_r == `AWSC_OFS_UPPER_WAIT);
   wire fw_l = wr_pend_r & (wr_addr_r == `AWSC_OFS_LOWER_WAIT);
   wire fw_a = wr_pend_r & (wr_addr_r == `AWSC_OFS_ACCESS_STATE);
   wire [15:0] upper_area_wait_count_r_fw = fw_u ? (hwdata[15:0] & `AWSC_WMASK)
                                                 : upper_area_wait_count_r;
   wire [15:0] lower_area_wait_count_r_fw = fw_l ? (hwdata[15:0] & `AWSC_WMASK)
                                                 : lower_area_wait_count_r;
   wire [7:0]  access_state_control_fw   = fw_a ? hwdata[15:8] : access_state_control_r;
   // read data is registered from haddr at the edge that ends the address phase, so it is valid in the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (take & ~hwrite) begin
         case (haddr)
            `AWSC_OFS_UPPER_WAIT:
               hrdata <= {16'h0000, upper_area_wait_count_r_fw};
            `AWSC_OFS_LOWER_WAIT:
               hrdata <= {16'h0000, lower_area_wait_count_r_fw};
            `AWSC_OFS_ACCESS_STATE:
               hrdata <= {16'h0000, access_state_control_fw, 8'h00};
            `AWSC_OFS_STATUS:
               hrdata <= {12'h000, seq_states, last_area_r, 3'b000, seq_busy, 4'h0};
            default:
               hrdata <= 32'h0000_0000;
         endcase
      end
   end
   // ==========================================
   // per-area field selection
   wire [31:0] all_waits = {upper_area_wait_count_r, lower_area_wait_count_r};
   wire [23:0] area_wait;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_area
         assign area_wait[gi*3 +: 3] = all_waits[gi*4 +: 3];
      end
   endgenerate
   assign ext_wait_count  = area_wait[ext_area*3 +: 3];
   assign ext_three_state = access_state_control_r[ext_area];
   // ==========================================
   // access sequencing
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_area_r <= 8'h00;
      end else if (ext_req & ~seq_busy) begin
         last_area_r <= 8'h01 << ext_area;
      end
   end
   awsc_access_seq u_seq (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .start       (ext_req & ~seq_busy),
      .three_state (ext_three_state),
      .wait_count  (ext_wait_count),
      .busy        (seq_busy),
      .done_r      (seq_done),
      .states_r    (seq_states)
   );
   assign ext_busy   = seq_busy;
   assign ext_done   = seq_done;
   assign ext_states = seq_states;
endmodule // awsc_top

// File: verilog/awsc_consts.vh
// constants for the area wait-state control block
`ifndef AWSC_CONSTS_VH
`define AWSC_CONSTS_VH
// ==========================================
// register byte offsets
`define AWSC_OFS_UPPER_WAIT   12'h000
`define AWSC_OFS_LOWER_WAIT   12'h004
`define AWSC_OFS_ACCESS_STATE 12'h008
`define AWSC_OFS_STATUS       12'h00C
// ==========================================
// field layout and reset values
`define AWSC_WMASK            16'h7777
`define AWSC_WAIT_RESET       16'h7777
`define AWSC_AST_POS          8
`define AWSC_AST_RESET        8'hFF
`define AWSC_FIELD_W          3
`define AWSC_BASE_STATES      3'h2
// last base-state index of a 2-state and of a 3-state access
`define AWSC_LAST_T_TWO       2'b10
`define AWSC_LAST_T_THREE     2'b11
`endif

// File: verilog/awsc_access_seq.v
// access sequencer: 2-state external access, or 3-state external access with program waits
`timescale 1ns/1ps
`include "awsc_consts.vh"
module awsc_access_seq (
   input  wire       hclk,
   input  wire       hresetn,
   input  wire       start,
   input  wire       three_state,
   input  wire [2:0] wait_count,
   output wire       busy,
   output reg        done_r,
   output reg  [3:0] states_r
);
   // ==========================================
   // state machine
   localparam ST_IDLE = 2'b00;
   localparam ST_T    = 2'b01;
   localparam ST_WAIT = 2'b10;
   reg [1:0] state_r;
   reg [1:0] tcnt_r;
   reg [2:0] wcnt_r;
   reg       three_r;
   reg [3:0] scnt_r;
   assign busy = (state_r != ST_IDLE);
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r  <= ST_IDLE;
         tcnt_r   <= 2'b00;
         wcnt_r   <= 3'b000;
         three_r  <= 1'b0;
         scnt_r   <= 4'h0;
         done_r   <= 1'b0;
         states_r <= 4'h0;
      end else begin
         done_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  // latched once per access, so later writes wait for the next one
                  three_r <= three_state;
                  wcnt_r  <= three_state ? wait_count : 3'b000;
                  tcnt_r  <= 2'b01;
                  scnt_r  <= 4'h1;
                  state_r <= ST_T;
               end
            end
            ST_T: begin
               scnt_r <= scnt_r + 4'h1;
               if (tcnt_r == (three_r ? `AWSC_LAST_T_THREE : `AWSC_LAST_T_TWO)) begin
                  if (wcnt_r != 3'b000) begin
                     state_r <= ST_WAIT;
                  end else begin
                     state_r  <= ST_IDLE;
                     done_r   <= 1'b1;
                     states_r <= scnt_r;
                  end
               end else begin
                  tcnt_r <= tcnt_r + 2'b01;
               end
            end
            ST_WAIT: begin
               wcnt_r <= wcnt_r - 3'b001;
               if (wcnt_r == 3'b001) begin
                  state_r  <= ST_IDLE;
                  done_r   <= 1'b1;
                  states_r <= scnt_r;
               end else begin
                  scnt_r <= scnt_r + 4'h1;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule // awsc_access_seq

// File: testbench/awsc_chk_asserts.sv
// checker on the ports of the area wait-state control top
`timescale 1ns/1ps
module awsc_chk (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        ext_req,
   input wire logic        ext_busy,
   input wire logic        ext_done,
   input wire logic [2:0]  ext_wait_count,
   input wire logic        ext_three_state,
   input wire logic [3:0]  ext_states
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [3:0] n_r;
   logic [3:0] cnt_r;
   logic       rd_r;
   wire        take = ext_req && !ext_busy;
   wire        rd_take = hsel && htrans[1] && !hwrite;
   // ========
   // length latched at start, so later writes cannot leak in
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         n_r <= 4'h0;
         cnt_r <= 4'h0;
         rd_r <= 1'b0;
      end else begin
         if (take) n_r <= ext_three_state ? 4'h3 + {1'b0, ext_wait_count} : 4'h2;
         cnt_r <= take ? 4'h0 : cnt_r + {3'h0, ext_busy};
         rd_r <= rd_take && haddr < 12'h008;
      end
   end
   chk_busy_len: assert property ($fell(ext_busy) |-> cnt_r == n_r)
      else $error("bad access length");
   chk_done_states: assert property (ext_done |-> ext_states == n_r)
      else $error("bad state count");
   chk_two_state: assert property (
      take && !ext_three_state |=> ext_busy [*2] ##1 !ext_busy)
      else $error("bad 2-state access");
   chk_wait_max: assert property (
      take && ext_three_state && ext_wait_count == 3'h7 |=> ext_busy [*8])
      else $error("seven waits cut short");
   chk_resp_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not okay");
   chk_done_pulse: assert property (ext_done |=> !ext_done)
      else $error("done too long");
   chk_idle_quiet: assert property (!ext_busy && !ext_req |=> !ext_busy)
      else $error("access without request");
   chk_rsvd_zero: assert property (rd_r |-> (hrdata & 32'h0000_8888) == 32'h0)
      else $error("reserved bit set");
   chk_rdata_hold: assert property (!rd_take |=> $stable(hrdata))
      else $error("read data moved");
   cover property (take && ext_three_state && ext_wait_count == 3'h0);
   cover property (take && !ext_three_state);
   cover property (rd_r);
endmodule // awsc_chk
bind awsc_top awsc_chk awsc_chk_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata), .ext_req(ext_req),
   .hreadyout(hreadyout), .hresp(hresp),
   .ext_busy(ext_busy), .ext_done(ext_done), .ext_wait_count(ext_wait_count),
   .ext_three_state(ext_three_state), .ext_states(ext_states));

// File: testbench/awsc_ext_dev.sv
// external device model: times each access by its strobe
`timescale 1ns/1ps
module awsc_ext_dev (
   input  wire logic       hclk,
   input  wire logic       ext_busy,
   output logic            fin_r,
   output logic [3:0]      len_r
);
   logic [3:0] run_r = 4'h0;
   // measured on the wire, never taken from the block's own report
   always @(posedge hclk) begin
      fin_r <= !ext_busy && run_r != 4'h0;
      if (!ext_busy && run_r != 4'h0) len_r <= run_r;
      run_r <= ext_busy ? run_r + 4'h1 : 4'h0;
   end
endmodule // awsc_ext_dev

// File: testbench/testbench.sv
// self-checking bench for the area wait-state control block
`timescale 1ns/1ps
module testbench;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext_req = 0;
   logic [11:0] haddr = 0;
   logic [1:0]  htrans = 0;
   logic [31:0] hwdata = 0, rd, hw;
   logic [2:0]  ext_area = 0;
   logic [15:0] up, lo;
   logic [7:0]  ast;
   logic [3:0]  exp_q[$];
   wire  [31:0] hrdata;
   wire  [3:0]  ext_states, len_r;
   wire         hreadyout, ext_busy, fin_r;
   int          err_count = 0, checked = 0, seed = 75, cyc = 0, k, a;
   always #2.5 hclk = ~hclk;
   awsc_top awsc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .ext_req(ext_req),
      .ext_area(ext_area), .ext_busy(ext_busy), .ext_done(), .ext_wait_count(),
      .ext_three_state(), .ext_states(ext_states));
   awsc_ext_dev awsc_ext_dev_inst (.hclk(hclk), .ext_busy(ext_busy), .fin_r(fin_r),
      .len_r(len_r));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic ahb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= ad;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   function automatic logic [3:0] nexp(input int ar);
      logic [15:0] r;
      r = ar > 3 ? up : lo;
      return ast[ar] ? 4'h3 + {1'b0, r[(ar % 4) * 4 +: 3]} : 4'h2;
   endfunction
   // expectation noted at the start edge, before any mid-access write
   task automatic go(input int ar);
      ext_req <= 1'b1;
      ext_area <= ar[2:0];
      @(posedge hclk);
      ext_req <= 1'b0;
      exp_q.push_back(nexp(ar));
   endtask
   task automatic wait_fin;
      while (fin_r !== 1'b1) @(posedge hclk);
      @(posedge hclk);
   endtask
   // ========
   // watcher and timeout
   always @(posedge hclk) begin
      if (fin_r === 1'b1 && exp_q.size() > 0) begin
         chk(32'(len_r), 32'(exp_q[0]));
         chk(32'(ext_states), 32'(exp_q.pop_front()));
      end else if (fin_r === 1'b1) begin
         chk(32'(len_r), 32'h0);
      end
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         close_out;
      end
   end
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      up = 16'h7777;
      lo = 16'h7777;
      ast = 8'hff;
      for (k = 0; k < 3; k++) begin
         ahb(1'b0, 12'(4 * k), 32'h0);
         chk(rd, k == 2 ? 32'h0000_ff00 : 32'h0000_7777);
      end
      go(7);
      wait_fin;
      $display("reset values done");
      for (k = 0; k < 4; k++) begin
         hw = k < 2 ? 32'hffff_ffff : $random(seed);
         ahb(1'b1, 12'(4 * (k % 2)), hw);
         ahb(1'b0, 12'(4 * (k % 2)), 32'h0);
         chk(rd, hw & 32'h0000_7777);
         if (k % 2) lo = hw[15:0] & 16'h7777;
         else up = hw[15:0] & 16'h7777;
      end
      ahb(1'b1, 12'h010, 32'hffff_ffff);
      ahb(1'b0, 12'h010, 32'h0);
      chk(rd, 32'h0);
      $display("register access done");
      for (k = 0; k < 3; k++) begin
         ast = k == 0 ? 8'hff : k == 1 ? 8'h00 : 8'h5a;
         if (k == 2) lo = 16'h0000;
         ahb(1'b1, 12'h004, {16'h0, lo});
         ahb(1'b1, 12'h008, {16'h0, ast, 8'hff});
         ahb(1'b0, 12'h008, 32'h0);
         chk(rd, {16'h0, ast, 8'h00});
         for (a = 0; a < 8; a++) begin
            go(a);
            wait_fin;
         end
      end
      $display("area passes done");
      go(4);
      hw = $random(seed);
      ahb(1'b1, 12'h000, hw);
      up = hw[15:0] & 16'h7777;
      wait_fin;
      go(4);
      wait_fin;
      ahb(1'b0, 12'h00C, 32'h0);
      chk(rd, {12'h000, nexp(4), 8'h10, 8'h00});
      chk(32'(exp_q.size()), 32'h0);
      $display("mid-access write done");
      close_out;
   end
endmodule // testbench
